// file: design/drb_defines.svh
`ifndef DRB_DEFINES_SVH
`define DRB_DEFINES_SVH

// ----------------------------------------
// serial frame layout
// ----------------------------------------
`define DRB_RW_BIT 23
`define DRB_DEV_HI 22
`define DRB_DEV_LO 21
`define DRB_IDX_MSB 20
`define DRB_IDX_LSB 16
`define DRB_FRAME_BITS 6'h18
`define DRB_FRAME_BITS_PEC 6'h20
`define DRB_CNT_MAX 6'h3f

// ----------------------------------------
// register indices
// ----------------------------------------
`define DRB_N_REGS 27
`define DRB_IDX_SLEW_FIRST 5'h14
`define DRB_IDX_SLEW_LAST 5'h17
`define DRB_IDX_STATUS 5'h18
`define DRB_IDX_MAIN 5'h19
`define DRB_IDX_LAST 5'h1a
`define DRB_IDX_SOFT 5'h1d

// ----------------------------------------
// fields, masks and crc polynomial
// ----------------------------------------
`define DRB_MAIN_PEC_BIT 2
`define DRB_MAIN_SOW_BIT 3
`define DRB_SOFT_TOGGLE_BIT 12
`define DRB_SLEW_EN_BIT 12
`define DRB_SLEW_FIX_MSB 15
`define DRB_SLEW_FIX_LSB 13
`define DRB_SLEW_KEEP 16'h107f
`define DRB_ST_BOOST_LSB 12
`define DRB_ST_TOGGLE 11
`define DRB_ST_CRC 10
`define DRB_ST_RAMP 9
`define DRB_ST_OTEMP 8
`define DRB_ST_VOUT_LSB 4
`define DRB_ST_IOUT_LSB 0
`define DRB_CRC_POLY 8'h07

// ----------------------------------------
// host port map and timing
// ----------------------------------------
`define DRB_H_FRAME_LO 4'h0
`define DRB_H_FRAME_HI 4'h1
`define DRB_H_CTRL 4'h2
`define DRB_H_STAT 4'h3
`define DRB_H_RX_LO 4'h4
`define DRB_H_RX_HI 4'h5
`define DRB_CLK_NS 50
`define DRB_SCLK_HALF_NS 400
`define DRB_SCLK_HALF 4'((`DRB_SCLK_HALF_NS + `DRB_CLK_NS - 1) / `DRB_CLK_NS)

`endif

// file: design/drb_pkg.sv
package drb_pkg;
  `include "drb_defines.svh"

  typedef enum logic [2:0] {
    DRB_IDLE,
    DRB_LEAD,
    DRB_HIGH,
    DRB_LOW,
    DRB_TAIL,
    DRB_GAP
  } drb_host_state_t;

  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] sync_s;
    logic [1:0] sdin_s;
    logic sclk_p;
    logic sync_p;
    logic [31:0] rx;
    logic [5:0] cnt;
    logic [31:0] tx;
    logic sdo;
    logic rd_pend;
    logic [4:0] rd_idx;
    logic crc_err;
    logic toggle;
    logic fault_n;
    logic [15:0] status;
    logic [`DRB_N_REGS-1:0][15:0] regs;
  } drb_dev_st_t;

  typedef struct packed {
    drb_host_state_t st;
    logic [3:0] div;
    logic [5:0] bitcnt;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [15:0] flo;
    logic [7:0] fhi;
    logic pec;
    logic sclk;
    logic sync_n;
    logic sdin;
    logic [1:0] sdo_s;
    logic [15:0] rdata;
  } drb_host_st_t;

  // crc-8, polynomial x^8+x^2+x+1, msb first
  function automatic logic [7:0] drb_crc8(input logic [23:0] w);
    logic [7:0] c;
    logic fb;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      fb = c[7] ^ w[i];
      c = {c[6:0], 1'b0} ^ (fb ? `DRB_CRC_POLY : 8'h00);
    end
    return c;
  endfunction : drb_crc8
endpackage : drb_pkg

// file: design/drb_link_if.sv
`timescale 1ns/100ps
interface drb_link_if;
  logic sclk;
  logic sync_n;
  logic sdin;
  logic sdo;

  modport host (
    output sclk,
    output sync_n,
    output sdin,
    input sdo
  );

  modport dev (
    input sclk,
    input sync_n,
    input sdin,
    output sdo
  );
endinterface : drb_link_if

// file: design/drb_dev.sv
`timescale 1ns/100ps
`include "drb_defines.svh"
// Contract
// R1: host reads gain A of device 1 with 0xA80000
// R2: after a read, next frame read or nop
// R3: next transfer shifts selected register out
// R4: slew write needs 000 on top bits
// R5: read flag, device address, register index
// R6: indices 0-7 data and control registers
// R7: indices 8-15 gain and offset registers
// R8: indices 16-23 clear code and slew
// R9: 24 status, 25 main, 26 converter control
// R10: status register cannot be written
// R11: ramp flag D9, toggle flag D11
// R12: status-on-write shifts status every write
// R13: otherwise status only through readback
// R14: boost, crc, temperature and fault bit layout
// R15: current mode boost failure also flags current fault
// R16: voltage mode boost failure sets boost flag
// R17: boost flags leave fault pin alone; code pulls it low for current-mode channels through the current fault
// R18: toggle flag follows software register write
// R19: readback is eight filler bits, sixteen data
// R20: with crc, readback grows to 32 bits
// R21: crc flag marks last word failed check
// R22: ramp flag set while any channel slews; code counts only channels whose slew enable bit D12 is set
// R23: unused indices read back as zero
module drb_dev #(
  parameter logic [1:0] DEV_ADDR = 2'h1
) (
  input wire logic core_clk,
  input wire logic reset,
  drb_link_if.dev link,
  input wire logic boost_flag_ch_a,
  input wire logic boost_flag_ch_b,
  input wire logic boost_flag_ch_c,
  input wire logic boost_flag_ch_d,
  input wire logic [3:0] current_mode,
  input wire logic [3:0] vout_fault,
  input wire logic [3:0] iout_fault,
  input wire logic over_temp,
  input wire logic [3:0] slewing,
  output logic fault_n,
  output logic [15:0] status
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam drb_pkg::drb_dev_st_t DEV_RST = '{
    sync_s: 2'h3,
    sync_p: 1'b1,
    fault_n: 1'b1,
    default: '0
  };

  drb_pkg::drb_dev_st_t q;
  drb_pkg::drb_dev_st_t d;

  function automatic logic is_slew(input logic [4:0] idx);
    return idx >= `DRB_IDX_SLEW_FIRST && idx <= `DRB_IDX_SLEW_LAST;
  endfunction : is_slew

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic pec;
    logic [5:0] nbits;
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic [23:0] word;
    logic [4:0] idx;
    logic [15:0] wdat;
    logic [15:0] payload;
    logic crc_ok;
    logic [3:0] boost;
    logic [3:0] iout_eff;
    logic ramp;
    logic [15:0] st;
    pec = 1'b0;
    nbits = 6'h00;
    start = 1'b0;
    stop = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    word = 24'h000000;
    idx = 5'h00;
    wdat = 16'h0000;
    payload = 16'h0000;
    crc_ok = 1'b0;
    boost = 4'h0;
    iout_eff = 4'h0;
    ramp = 1'b0;
    st = 16'h0000;
    d = q;

    // first stage of each synchroniser feeds only the second
    d.sclk_s = {q.sclk_s[0], link.sclk};
    d.sync_s = {q.sync_s[0], link.sync_n};
    d.sdin_s = {q.sdin_s[0], link.sdin};
    d.sclk_p = q.sclk_s[1];
    d.sync_p = q.sync_s[1];

    pec = q.regs[`DRB_IDX_MAIN][`DRB_MAIN_PEC_BIT];
    nbits = pec ? `DRB_FRAME_BITS_PEC : `DRB_FRAME_BITS;  // R20
    start = q.sync_p & ~q.sync_s[1];
    stop = ~q.sync_p & q.sync_s[1];
    rise = ~q.sync_s[1] & ~q.sclk_p & q.sclk_s[1];
    fall = ~q.sync_s[1] & q.sclk_p & ~q.sclk_s[1];
    word = pec ? q.rx[31:8] : q.rx[23:0];
    idx = word[`DRB_IDX_MSB:`DRB_IDX_LSB];  // R5
    wdat = word[15:0];

    // ----------------------------------------
    // frame start: choose what goes out on sdo
    // ----------------------------------------
    if (start) begin
      if (q.rd_pend) begin
        if (q.rd_idx == `DRB_IDX_STATUS) begin
          payload = q.status;  // R9 R13
        end else if (q.rd_idx > `DRB_IDX_LAST) begin
          payload = 16'h0000;  // R23
        end else begin
          payload = q.regs[q.rd_idx];  // R3 R6 R7 R8 R9
        end
      end else if (q.regs[`DRB_IDX_MAIN][`DRB_MAIN_SOW_BIT]) begin
        payload = q.status;  // R12
      end
      // filler byte first, data, then crc or padding
      d.tx = {8'h00, payload, pec ? drb_pkg::drb_crc8({8'h00, payload}) : 8'h00};  // R19 R20
      d.cnt = 6'h00;
      d.rd_pend = 1'b0;
      d.sdo = 1'b0;
    end

    // sdo changes on rising sclk, host samples on falling
    if (rise) begin
      d.sdo = q.tx[31];
      d.tx = {q.tx[30:0], 1'b0};
    end

    if (fall && q.cnt != `DRB_CNT_MAX) begin
      d.rx = {q.rx[30:0], q.sdin_s[1]};
      d.cnt = q.cnt + 6'h01;
    end

    // ----------------------------------------
    // frame end: check and decode
    // ----------------------------------------
    // a frame of the wrong length is dropped whole
    if (stop && q.cnt == nbits) begin
      crc_ok = !pec || drb_pkg::drb_crc8(q.rx[31:8]) == q.rx[7:0];
      d.crc_err = ~crc_ok;  // R21
      if (crc_ok && word[`DRB_DEV_HI:`DRB_DEV_LO] == DEV_ADDR) begin
        if (word[`DRB_RW_BIT]) begin
          d.rd_pend = 1'b1;  // R1 R2
          d.rd_idx = idx;
        end else if (idx == `DRB_IDX_SOFT) begin
          d.toggle = wdat[`DRB_SOFT_TOGGLE_BIT];  // R18
        end else if (idx <= `DRB_IDX_LAST && idx != `DRB_IDX_STATUS) begin  // R10
          if (!is_slew(idx)) begin
            d.regs[idx] = wdat;
          end else if (wdat[`DRB_SLEW_FIX_MSB:`DRB_SLEW_FIX_LSB] == 3'h0) begin
            d.regs[idx] = wdat & `DRB_SLEW_KEEP;  // R4
          end
        end
      end
    end

    // ----------------------------------------
    // status register
    // ----------------------------------------
    boost = {boost_flag_ch_d, boost_flag_ch_c, boost_flag_ch_b, boost_flag_ch_a};  // R16
    // a current-mode converter out of compliance is a current fault too
    iout_eff = iout_fault | (boost & current_mode);  // R15
    for (int i = 0; i < 4; i++) begin
      ramp = ramp | (slewing[i] & q.regs[32'(`DRB_IDX_SLEW_FIRST) + i][`DRB_SLEW_EN_BIT]);  // R22
    end
    st[`DRB_ST_BOOST_LSB +: 4] = boost;  // R14
    st[`DRB_ST_TOGGLE] = q.toggle;  // R11
    st[`DRB_ST_CRC] = q.crc_err;
    st[`DRB_ST_RAMP] = ramp;  // R11
    st[`DRB_ST_OTEMP] = over_temp;
    st[`DRB_ST_VOUT_LSB +: 4] = vout_fault;
    st[`DRB_ST_IOUT_LSB +: 4] = iout_eff;
    d.status = st;
    // converter flags reach the shared fault pin only as current faults of current-mode channels
    d.fault_n = ~(|vout_fault | |iout_eff | over_temp);  // R17
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  assign link.sdo = q.sdo;
  assign fault_n = q.fault_n;
  assign status = q.status;

endmodule : drb_dev

// file: design/drb_host.sv
`timescale 1ns/100ps
`include "drb_defines.svh"
module drb_host (
  input wire logic core_clk,
  input wire logic reset,
  drb_link_if.host link,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam drb_pkg::drb_host_st_t HOST_RST = '{
    st: drb_pkg::DRB_IDLE,
    sync_n: 1'b1,
    default: '0
  };

  drb_pkg::drb_host_st_t q;
  drb_pkg::drb_host_st_t d;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [5:0] nbits;
    logic half_end;
    logic [23:0] word;
    nbits = q.pec ? `DRB_FRAME_BITS_PEC : `DRB_FRAME_BITS;
    half_end = q.div == `DRB_SCLK_HALF - 4'h1;
    word = {wdata[7:0], q.flo};
    d = q;
    d.sdo_s = {q.sdo_s[0], link.sdo};
    d.rdata = 16'h0000;
    d.div = half_end ? 4'h0 : q.div + 4'h1;

    if (rd) begin
      unique case (addr)
        `DRB_H_FRAME_LO: d.rdata = q.flo;
        `DRB_H_FRAME_HI: d.rdata = {8'h00, q.fhi};
        `DRB_H_CTRL: d.rdata = {15'h0000, q.pec};
        `DRB_H_STAT: d.rdata = {15'h0000, q.st != drb_pkg::DRB_IDLE};
        `DRB_H_RX_LO: d.rdata = q.pec ? q.rx[23:8] : q.rx[15:0];
        `DRB_H_RX_HI: d.rdata = q.pec ? {8'h00, q.rx[7:0]} : 16'h0000;
        default: d.rdata = 16'h0000;
      endcase
    end

    unique case (q.st)
      drb_pkg::DRB_IDLE: begin
        d.div = 4'h0;
        // writes that would disturb a frame are ignored while busy
        if (wr && addr == `DRB_H_FRAME_LO) begin
          d.flo = wdata;
        end
        if (wr && addr == `DRB_H_CTRL) begin
          d.pec = wdata[0];
        end
        if (wr && addr == `DRB_H_FRAME_HI) begin
          d.fhi = wdata[7:0];
          d.tx = {word, q.pec ? drb_pkg::drb_crc8(word) : 8'h00};  // R1 R5 R20
          d.bitcnt = 6'h00;
          d.rx = 32'h00000000;
          d.sync_n = 1'b0;
          d.st = drb_pkg::DRB_LEAD;
        end
      end
      drb_pkg::DRB_LEAD,
      drb_pkg::DRB_LOW: begin
        if (half_end) begin
          if (q.st == drb_pkg::DRB_LOW && q.bitcnt == nbits) begin
            d.st = drb_pkg::DRB_TAIL;
          end else begin
            d.sclk = 1'b1;
            d.sdin = q.tx[31];
            d.tx = {q.tx[30:0], 1'b0};
            d.st = drb_pkg::DRB_HIGH;
          end
        end
      end
      drb_pkg::DRB_HIGH: begin
        // late in the high phase so the double-synced sdo has settled
        if (half_end) begin
          d.sclk = 1'b0;
          d.rx = {q.rx[30:0], q.sdo_s[1]};
          d.bitcnt = q.bitcnt + 6'h01;
          d.st = drb_pkg::DRB_LOW;
        end
      end
      drb_pkg::DRB_TAIL: begin
        if (half_end) begin
          d.sync_n = 1'b1;
          d.sdin = 1'b0;
          d.st = drb_pkg::DRB_GAP;
        end
      end
      drb_pkg::DRB_GAP: begin
        // idle gap so the device sees sync high for several samples
        if (half_end) begin
          d.st = drb_pkg::DRB_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= HOST_RST;
    end else begin
      q <= d;
    end
  end

  assign link.sclk = q.sclk;
  assign link.sync_n = q.sync_n;
  assign link.sdin = q.sdin;
  assign rdata = q.rdata;

endmodule : drb_host

// file: sim/drb_chk.sv
`timescale 1ns/100ps
module drb_chk (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  input wire logic sdo
);
  logic [5:0] edges_q;
  logic sclk_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      edges_q <= 6'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (sync_n) begin
        edges_q <= 6'h00;
      end else if (sclk && !sclk_q) begin
        edges_q <= edges_q + 6'h01;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // link timing
  // ----------------------------------------
  // clock must stay parked between frames; the device ignores sclk edges while sync is high
  a_sclk_idle: assert property (sync_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  a_frame_bits: assert property ($rose(sync_n) |-> edges_q == 6'h18 || edges_q == 6'h20)
    else $error("frame length not 24 or 32 clocks");
  a_frame_lead: assert property ($fell(sync_n) |-> !sclk [*8] ##1 sclk)
    else $error("first serial clock not 8 cycles after select");
  a_high_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high phase not 8 cycles");
  a_low_half: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("serial clock low phase under 8 cycles");
  a_frame_gap: assert property ($rose(sync_n) |-> sync_n [*8])
    else $error("frames too close together");
  a_sdin_hold: assert property (sclk && $past(sclk) |-> $stable(sdin))
    else $error("host data moved while clock high");
  a_sdo_hold: assert property ($fell(sclk) |-> sdo == $past(sdo, 2))
    else $error("device data not settled at sampling edge");
endmodule : drb_chk

// file: sim/tb_dac_readback_and_status.sv
`timescale 1ns/100ps
`include "drb_defines.svh"
module tb_dac_readback_and_status;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [3:0] bst = 4'h0;
  logic [3:0] cmode = 4'h0;
  logic [3:0] vf = 4'h0;
  logic [3:0] ifl = 4'h0;
  logic ot = 1'b0;
  logic [3:0] slw = 4'h0;
  logic fault_n;
  logic [15:0] status;
  logic [15:0] got;
  int bad_count = 0;
  int total_checks = 0;

  drb_link_if link ();
  drb_host drb_host_i (.core_clk(core_clk), .reset(reset), .link(link.host), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  drb_dev #(.DEV_ADDR(2'h1)) drb_dev_i (.core_clk(core_clk), .reset(reset), .link(link.dev),
    .boost_flag_ch_a(bst[0]), .boost_flag_ch_b(bst[1]), .boost_flag_ch_c(bst[2]),
    .boost_flag_ch_d(bst[3]), .current_mode(cmode), .vout_fault(vf), .iout_fault(ifl),
    .over_temp(ot), .slewing(slw), .fault_n(fault_n), .status(status));
  drb_chk drb_chk_i (.core_clk(core_clk), .reset(reset), .sclk(link.sclk),
    .sync_n(link.sync_n), .sdin(link.sdin), .sdo(link.sdo));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    total_checks++;
    if (act !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, act, exp);
    end
  endtask : chk

  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd

  // busy is polled, not waited out, so a hung link shows as a mismatch
  task automatic xfer(input logic [23:0] w, output logic [15:0] rx);
    logic [15:0] s;
    s = 16'h0001;
    bus_wr(`DRB_H_FRAME_LO, w[15:0]);
    bus_wr(`DRB_H_FRAME_HI, {8'h00, w[23:16]});
    repeat (4) @(posedge core_clk);
    for (int n = 0; n < 300 && s[0] !== 1'b0; n++) bus_rd(`DRB_H_STAT, s);
    chk(s & 16'h0001, 16'h0000);
    bus_rd(`DRB_H_RX_LO, rx);
  endtask : xfer

  function automatic logic [23:0] fw(input logic rw, input logic [1:0] dv,
    input logic [4:0] ix, input logic [15:0] d);
    return {rw, dv, ix, d};
  endfunction : fw

  function automatic logic [15:0] val(input logic [4:0] i);
    return {3'b000, i, 8'h51};
  endfunction : val

  // slew keeps only enable and the low seven bits; status is all clear here
  function automatic logic [15:0] expv(input logic [4:0] i);
    if (i >= 5'h14 && i <= 5'h17) return val(i) & 16'h107f;
    if (i == 5'h18 || i > 5'h1a) return 16'h0000;
    return val(i);
  endfunction : expv

  task automatic rdreg(input logic [4:0] ix, input logic [15:0] e);
    logic [15:0] x;
    xfer(fw(1'b1, 2'h1, ix, 16'h0000), x);
    xfer(24'h3ce000, x);
    chk(x, e);
  endtask : rdreg

  task automatic close_out();
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    #4000000;
    bad_count++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk(status, 16'h0000);
    chk({15'h0000, fault_n}, 16'h0001);
    for (int i = 0; i < 27; i++) begin
      if (i != 24) xfer(fw(1'b0, 2'h1, 5'(i), val(5'(i))), got);
    end
    xfer(24'ha80000, got);
    xfer(24'h3ce000, got);
    chk(got, val(5'h08));
    xfer(fw(1'b1, 2'h1, 5'h00, 16'hffff), got);
    for (int i = 1; i <= 32; i++) begin
      xfer(i < 32 ? fw(1'b1, 2'h1, 5'(i), 16'h0000) : 24'h3ce000, got);
      chk(got, expv(5'(i - 1)));
    end
    xfer(fw(1'b0, 2'h1, 5'h14, 16'he07f), got);
    rdreg(5'h14, expv(5'h14));
    xfer(fw(1'b0, 2'h1, 5'h15, 16'h0f85), got);
    rdreg(5'h15, 16'h0005);
    xfer(fw(1'b0, 2'h2, 5'h08, 16'hdead), got);
    rdreg(5'h08, val(5'h08));
    @(posedge core_clk);
    bst <= 4'h6;
    cmode <= 4'h2;
    ot <= 1'b1;
    vf <= 4'h8;
    ifl <= 4'h8;
    slw <= 4'h1;
    xfer(fw(1'b0, 2'h1, 5'h1d, 16'h1000), got);
    chk(status, 16'h6b8a);
    chk({15'h0000, fault_n}, 16'h0000);
    rdreg(5'h18, 16'h6b8a);
    @(posedge core_clk);
    cmode <= 4'h0;
    ot <= 1'b0;
    vf <= 4'h0;
    ifl <= 4'h0;
    slw <= 4'h0;
    xfer(fw(1'b0, 2'h1, 5'h18, 16'hffff), got);
    chk(status, 16'h6800);
    chk({15'h0000, fault_n}, 16'h0001);
    xfer(fw(1'b0, 2'h1, 5'h19, 16'h0008), got);
    xfer(fw(1'b0, 2'h1, 5'h00, 16'h0001), got);
    chk(got, 16'h6800);
    xfer(fw(1'b0, 2'h1, 5'h19, 16'h0000), got);
    rdreg(5'h18, 16'h6800);
    xfer(fw(1'b0, 2'h1, 5'h1d, 16'h0000), got);
    chk(status, 16'h6000);
    xfer(fw(1'b0, 2'h1, 5'h19, 16'h0004), got);
    bus_wr(`DRB_H_CTRL, 16'h0001);
    bus_rd(`DRB_H_CTRL, got);
    chk(got, 16'h0001);
    rdreg(5'h08, val(5'h08));
    // crc8 of filler byte and gain A value, worked out by hand
    bus_rd(`DRB_H_RX_HI, got);
    chk(got, 16'h0018);
    bus_rd(`DRB_H_FRAME_LO, got);
    chk(got, 16'he000);
    bus_rd(`DRB_H_FRAME_HI, got);
    chk(got, 16'h003c);
    chk(status, 16'h6000);
    close_out();
  end
endmodule : tb_dac_readback_and_status
